// *** shared/srp_defs.svh ***
`ifndef SRP_DEFS_SVH
`define SRP_DEFS_SVH

// ************************************************************
// Field widths
// ************************************************************
`define SRP_AW 5
`define SRP_DW 16
`define SRP_CW 6

// ************************************************************
// Frame layout
// ************************************************************
`define SRP_PRE_LEN 6'h20
`define SRP_FIELD_LAST 6'h04
`define SRP_TA_LAST 6'h01
`define SRP_DATA_LAST 6'h0F

// ************************************************************
// Reset values and fill words
// ************************************************************
`define SRP_ID_RESET 5'h00
`define SRP_NO_ANSWER 16'hFFFF

// ************************************************************
// Timing
// ************************************************************
`define SRP_CAP_WAIT 2'h2
`define SRP_LINK_MAX_KHZ 2500

`endif

// *** shared/srp_pkg.sv ***
`include "srp_defs.svh"

package srp_pkg;

  // ************************************************************
  // Frame states
  // ************************************************************
  typedef enum logic [2:0] {
    srp_pre = 3'h0,
    srp_st = 3'h1,
    srp_op = 3'h3,
    srp_phy = 3'h2,
    srp_reg = 3'h6,
    srp_ta = 3'h7,
    srp_dat = 3'h5
  } srp_state_t;

  // ************************************************************
  // Request towards the register core
  // ************************************************************
  typedef struct packed {
    logic wr;
    logic rd;
    logic [`SRP_AW-1:0] addr;
    logic [`SRP_DW-1:0] wdata;
  } srp_req_t;

  // ************************************************************
  // State on the serial clock
  // ************************************************************
  typedef struct packed {
    logic phy_s1;
    logic phy_s2;
    logic ack_s1;
    logic ack_s2;
    logic [`SRP_AW-1:0] id_s1;
    logic [`SRP_AW-1:0] id_s2;
    logic idok_s1;
    logic idok_s2;
    srp_state_t st;
    logic [`SRP_CW-1:0] cnt;
    logic is_rd;
    logic match;
    logic [`SRP_AW-1:0] addr;
    logic [`SRP_DW-1:0] shreg;
    logic rd_tgl;
    logic wr_tgl;
    logic oe;
    logic pt;
    logic dout;
    logic dir;
  } srp_link_t;

  // ************************************************************
  // State on the main clock
  // ************************************************************
  typedef struct packed {
    logic [`SRP_AW-1:0] strap_s1;
    logic [`SRP_AW-1:0] strap_s2;
    logic [1:0] cap_cnt;
    logic [`SRP_AW-1:0] id;
    logic id_ok;
    logic rt_s1;
    logic rt_s2;
    logic rt_s3;
    logic wt_s1;
    logic wt_s2;
    logic wt_s3;
    srp_req_t req;
    logic rd_get;
    logic [`SRP_DW-1:0] rword;
    logic ack_tgl;
  } srp_core_t;

endpackage

// *** verilog/srp_port.sv ***
// Notes on behaviour
// RULE1 - Register access travels as management serial frames
// RULE2 - Data bits referenced to serial clock rising edge
// RULE3 - Master keeps serial clock at most 2.5 MHz
// RULE4 - Master gives three serial clocks during reset
// RULE5 - Valid deassertion resynchronises the frame decoder
// RULE6 - Valid tied low means every command valid
// RULE7 - Identity strap captured at reset release, held
// RULE8 - Latched identity selects this chip
// RULE9 - Pass-through bit routes data to gated pin
// RULE10 - Serial clock copied out buffered
// RULE11 - Direction high driving out, low inbound
// RULE12 - Direction low whenever no access runs
// RULE13 - Low reset input resets the device
// RULE14 - Foreign address frames ignored, line undriven; with phy access a foreign read drives the line from the gated pin
// RULE15 - Read drives second turnaround and data MSB first
`include "srp_defs.svh"

module srp_port (
  // Clocks and reset
  input wire logic mclk_i,
  input wire logic nrst_i,
  input wire logic register_serial_clock_i,
  // Serial data pin, command valid, direction and buffered clock
  input wire logic register_serial_data_i,
  output logic register_serial_data_o,
  output logic register_serial_data_oe_o,
  input wire logic serial_command_valid_n_i,
  output logic serial_data_direction_o,
  output logic buffered_serial_clock_o,
  // Gated physical-layer data pin
  input wire logic gated_phy_serial_data_i,
  output logic gated_phy_serial_data_o,
  output logic gated_phy_serial_data_oe_o,
  // Strap and configuration
  input wire logic [`SRP_AW-1:0] chip_identity_strap_i,
  input wire logic phy_access_i,
  // Register core side
  output srp_pkg::srp_req_t reg_req_o,
  input wire logic [`SRP_DW-1:0] reg_rdata_i
);
  import srp_pkg::*;

  srp_link_t l_ff;
  srp_link_t nxt_l;
  srp_core_t c_ff;
  srp_core_t nxt_c;
  logic din;
  logic own_rd;
  logic [`SRP_AW-1:0] phy_id;
  logic [`SRP_DW-1:0] word;
  logic first_bit;

  // ************************************************************
  // Serial clock domain: frame decoder
  // ************************************************************
  assign din = register_serial_data_i;
  assign own_rd = l_ff.match & l_ff.is_rd;
  assign phy_id = {l_ff.addr[`SRP_AW-2:0], din};
  // Word is stable whenever the answer toggle has come back
  assign word = (l_ff.ack_s2 == l_ff.rd_tgl) ? c_ff.rword
                                              : `SRP_NO_ANSWER;
  assign first_bit = own_rd & (l_ff.st == srp_dat) & (l_ff.cnt == 6'h00);

  always_comb begin
    nxt_l = l_ff;
    nxt_l.phy_s1 = phy_access_i;
    nxt_l.phy_s2 = l_ff.phy_s1;
    nxt_l.ack_s1 = c_ff.ack_tgl;
    nxt_l.ack_s2 = l_ff.ack_s1;
    nxt_l.id_s1 = c_ff.id;
    nxt_l.id_s2 = l_ff.id_s1;
    nxt_l.idok_s1 = c_ff.id_ok;
    nxt_l.idok_s2 = l_ff.idok_s1;
    nxt_l.cnt = l_ff.cnt + 6'h01;
    case (l_ff.st) // RULE1 RULE2
      srp_pre: begin
        if (din) begin
          if (l_ff.cnt == `SRP_PRE_LEN) begin
            nxt_l.cnt = l_ff.cnt;
          end
        end else begin
          if (l_ff.cnt == `SRP_PRE_LEN) begin
            nxt_l.st = srp_st;
          end
          nxt_l.cnt = 6'h00;
        end
      end
      srp_st: begin
        nxt_l.cnt = 6'h00;
        nxt_l.st = din ? srp_op : srp_pre;
      end
      srp_op: begin
        if (l_ff.cnt == 6'h00) begin
          nxt_l.is_rd = din;
        end else begin
          nxt_l.cnt = 6'h00;
          // Op codes 00 and 11 are not accesses
          nxt_l.st = (din != l_ff.is_rd) ? srp_phy : srp_pre;
        end
      end
      srp_phy: begin
        nxt_l.addr = phy_id;
        if (l_ff.cnt == `SRP_FIELD_LAST) begin
          nxt_l.cnt = 6'h00;
          nxt_l.st = srp_reg;
          nxt_l.match = l_ff.idok_s2 & (phy_id == l_ff.id_s2); // RULE8
        end
      end
      srp_reg: begin
        nxt_l.addr = phy_id;
        if (l_ff.cnt == `SRP_FIELD_LAST) begin
          nxt_l.cnt = 6'h00;
          nxt_l.st = srp_ta;
          if (own_rd) begin
            nxt_l.rd_tgl = ~l_ff.rd_tgl;
          end
        end
      end
      srp_ta: begin
        if (l_ff.cnt == 6'h00) begin
          if (own_rd) begin
            nxt_l.oe = 1'b1; // RULE15
            nxt_l.dout = 1'b0;
            nxt_l.dir = 1'b1; // RULE11
          end else if (l_ff.is_rd & l_ff.phy_s2) begin
            nxt_l.pt = 1'b1; // RULE9
            nxt_l.dir = 1'b1;
          end
        end else begin
          // Answer toggle is only synchronised after this edge
          nxt_l.cnt = 6'h00;
          nxt_l.st = srp_dat;
        end
      end
      srp_dat: begin
        if (l_ff.is_rd) begin
          if (l_ff.cnt == 6'h00) begin
            nxt_l.dout = word[`SRP_DW-2]; // RULE15
            nxt_l.shreg = {word[`SRP_DW-3:0], 2'b00};
          end else begin
            nxt_l.dout = l_ff.shreg[`SRP_DW-1];
            nxt_l.shreg = {l_ff.shreg[`SRP_DW-2:0], 1'b0};
          end
        end else begin
          nxt_l.shreg = {l_ff.shreg[`SRP_DW-2:0], din};
        end
        if (l_ff.cnt == `SRP_DATA_LAST) begin
          nxt_l.cnt = 6'h00;
          nxt_l.st = srp_pre;
          nxt_l.oe = 1'b0;
          nxt_l.pt = 1'b0;
          nxt_l.dout = 1'b0;
          nxt_l.dir = 1'b0; // RULE12
          if (l_ff.match & ~l_ff.is_rd) begin
            nxt_l.wr_tgl = ~l_ff.wr_tgl; // RULE8 RULE14
          end
        end
      end
      default: begin
        nxt_l.st = srp_pre;
        nxt_l.cnt = 6'h00;
      end
    endcase
    // Valid tied low simply never takes this branch
    if (serial_command_valid_n_i) begin // RULE5 RULE6
      nxt_l.st = srp_pre;
      nxt_l.cnt = 6'h00;
      nxt_l.oe = 1'b0;
      nxt_l.pt = 1'b0;
      nxt_l.dout = 1'b0;
      nxt_l.dir = 1'b0;
    end
  end

  always_ff @(posedge register_serial_clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      l_ff <= '0; // RULE13
    end else begin
      l_ff <= nxt_l;
    end
  end

  // ************************************************************
  // Pins
  // ************************************************************
  assign buffered_serial_clock_o = register_serial_clock_i; // RULE10
  // First data bit comes straight from the answer word: the shifter
  // could only hold it one slot late. Too fast a clock answers the fill word.
  assign register_serial_data_o = l_ff.pt ? gated_phy_serial_data_i :
                                  first_bit ? word[`SRP_DW-1] :
                                  l_ff.dout; // RULE15
  assign register_serial_data_oe_o = l_ff.oe | l_ff.pt;
  assign serial_data_direction_o = l_ff.dir;
  // Gated pin only follows the master while access is enabled
  assign gated_phy_serial_data_o = din; // RULE9
  assign gated_phy_serial_data_oe_o = l_ff.phy_s2 & ~l_ff.pt;

  // ************************************************************
  // Main clock domain: strap capture and core requests
  // ************************************************************
  always_comb begin
    nxt_c = c_ff;
    nxt_c.strap_s1 = chip_identity_strap_i;
    nxt_c.strap_s2 = c_ff.strap_s1;
    if (!c_ff.id_ok) begin
      if (c_ff.cap_cnt == `SRP_CAP_WAIT) begin
        nxt_c.id = c_ff.strap_s2; // RULE7
        nxt_c.id_ok = 1'b1;
      end else begin
        nxt_c.cap_cnt = c_ff.cap_cnt + 2'h1;
      end
    end
    nxt_c.rt_s1 = l_ff.rd_tgl;
    nxt_c.rt_s2 = c_ff.rt_s1;
    nxt_c.rt_s3 = c_ff.rt_s2;
    nxt_c.wt_s1 = l_ff.wr_tgl;
    nxt_c.wt_s2 = c_ff.wt_s1;
    nxt_c.wt_s3 = c_ff.wt_s2;
    nxt_c.req.rd = 1'b0;
    nxt_c.req.wr = 1'b0;
    // Address and data held on the serial side until next frame
    if (c_ff.rt_s2 != c_ff.rt_s3) begin
      nxt_c.req.rd = 1'b1;
      nxt_c.req.addr = l_ff.addr;
    end
    if (c_ff.wt_s2 != c_ff.wt_s3) begin
      nxt_c.req.wr = 1'b1;
      nxt_c.req.addr = l_ff.addr;
      nxt_c.req.wdata = l_ff.shreg;
    end
    nxt_c.rd_get = c_ff.req.rd;
    if (c_ff.rd_get) begin
      nxt_c.rword = reg_rdata_i;
      nxt_c.ack_tgl = ~c_ff.ack_tgl;
    end
  end

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      c_ff <= '0; // RULE13
    end else begin
      c_ff <= nxt_c;
    end
  end

  assign reg_req_o = c_ff.req;

  // ************************************************************
  // Checks on the serial clock
  // ************************************************************
  sequence s_own_read_go;
    l_ff.st == srp_ta && l_ff.cnt == 6'h00 && own_rd &&
      !serial_command_valid_n_i;
  endsequence

  sequence s_read_body;
    (!serial_command_valid_n_i)[*8] ##1
      (!serial_command_valid_n_i)[*8] ##1 !serial_command_valid_n_i;
  endsequence

  a_ta2_zero: assert property (@(posedge register_serial_clock_i)
    disable iff (!nrst_i) s_own_read_go |=> l_ff.oe && !l_ff.dout)
    else $error("turnaround bit not driven low"); // RULE15

  a_read_held: assert property (@(posedge register_serial_clock_i)
    disable iff (!nrst_i)
    s_own_read_go ##1 (!serial_command_valid_n_i)[*8] |-> l_ff.oe)
    else $error("read data released early"); // RULE15

  a_read_ends: assert property (@(posedge register_serial_clock_i)
    disable iff (!nrst_i) s_own_read_go ##1 s_read_body |=> !l_ff.oe)
    else $error("read data driven too long"); // RULE15

  a_valid_abort: assert property (@(posedge register_serial_clock_i)
    disable iff (!nrst_i) serial_command_valid_n_i |=>
    l_ff.st == srp_pre && !l_ff.oe && !l_ff.dir)
    else $error("frame kept after valid dropped"); // RULE5

  a_dir_idle: assert property (@(posedge register_serial_clock_i)
    disable iff (!nrst_i) l_ff.st == srp_pre |-> !l_ff.dir)
    else $error("direction out while idle"); // RULE12

  a_dir_follows: assert property (@(posedge register_serial_clock_i)
    disable iff (!nrst_i)
    serial_data_direction_o == register_serial_data_oe_o)
    else $error("direction differs from drive"); // RULE11

  a_ignore_other: assert property (@(posedge register_serial_clock_i)
    disable iff (!nrst_i) !l_ff.match |-> !l_ff.oe)
    else $error("foreign frame answered"); // RULE14

  a_gate_off: assert property (@(posedge register_serial_clock_i)
    disable iff (!nrst_i)
    !l_ff.phy_s2 |-> !gated_phy_serial_data_oe_o && !l_ff.pt)
    else $error("gated pin active while disabled"); // RULE9

  a_write_select: assert property (@(posedge register_serial_clock_i)
    disable iff (!nrst_i)
    l_ff.st == srp_dat && l_ff.cnt == `SRP_DATA_LAST && !l_ff.is_rd &&
    !serial_command_valid_n_i |=>
    (l_ff.wr_tgl != $past(l_ff.wr_tgl)) == $past(l_ff.match))
    else $error("write selection wrong"); // RULE8

  // ************************************************************
  // Checks on the main clock
  // ************************************************************
  a_id_take: assert property (@(posedge mclk_i) disable iff (!nrst_i)
    $rose(c_ff.id_ok) |-> c_ff.id == $past(c_ff.strap_s2))
    else $error("identity not taken from strap"); // RULE7

  a_id_hold: assert property (@(posedge mclk_i) disable iff (!nrst_i)
    c_ff.id_ok |=> c_ff.id_ok && $stable(c_ff.id))
    else $error("identity changed after capture"); // RULE7

  a_rd_answer: assert property (@(posedge mclk_i) disable iff (!nrst_i)
    reg_req_o.rd |=> ##1 c_ff.rword == $past(reg_rdata_i))
    else $error("read word not captured"); // RULE1

endmodule // srp_port

// *** testbench/srp_master.sv ***
module srp_master (
  // Link side
  output logic sclk_o,
  output logic sd_o,
  output logic sd_oe_o,
  output logic valid_n_o,
  input wire logic sd_i
);
  timeunit 1ns;
  timeprecision 1ns;

  // Slow enough for the core answer to cross back in time
  localparam int HALF = 200;

  initial begin
    sclk_o = 1'h0;
    sd_o = 1'h1;
    sd_oe_o = 1'h0;
    valid_n_o = 1'h0;
  end

  // Drive at the falling edge, sample just before the rising edge
  task automatic bit1(input logic oe, input logic b, output logic s);
    sd_oe_o = oe;
    sd_o = b;
    #HALF s = sd_i;
    sclk_o = 1'h1;
    #HALF sclk_o = 1'h0;
  endtask

  task automatic frame(input logic rd, input logic [4:0] phy, ra,
                       input logic [15:0] wd, output logic [16:0] q);
    logic [13:0] hd;
    logic [17:0] tail;
    logic s;
    hd = {2'h1, rd, ~rd, phy, ra};
    tail = {2'h2, wd};
    q = 17'h0;
    repeat (32) bit1(1'h1, 1'h1, s);
    for (int i = 13; i >= 0; i--) bit1(1'h1, hd[i], s);
    for (int i = 17; i >= 0; i--) begin
      bit1(~rd, tail[i], s);
      if (i < 17) q[i] = s;
    end
    sd_oe_o = 1'h0;
  endtask

  task automatic hold_invalid(input int n);
    logic s;
    valid_n_o = 1'h1;
    repeat (n) bit1(1'h0, 1'h1, s);
    valid_n_o = 1'h0;
  endtask
endmodule // srp_master

// *** testbench/serial_register_port_tb.sv ***
module serial_register_port_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import srp_pkg::*;

  localparam logic [4:0] ID = 5'h0B;
  localparam logic [4:0] ALT = 5'h15;
  logic mclk, nrst, phy_acc, phy_val;
  logic [4:0] strap;
  logic [15:0] rdata;
  srp_req_t req;
  logic sd_o, sd_oe, dir, bclk, g_o, g_oe, m_d, m_oe, sclk, vn, s;
  logic [16:0] q;
  int fail_count = 0;
  int checks_done = 0;
  int wr_n = 0;
  int rd_n = 0;
  int oe_n = 0;
  // Weak pull-up on the serial data pin; gated pin idles at phy_val
  wire logic line = sd_oe ? sd_o : (m_oe ? m_d : 1'h1);
  wire logic gline = g_oe ? g_o : phy_val;

  srp_master m (.sclk_o(sclk), .sd_o(m_d), .sd_oe_o(m_oe),
                .valid_n_o(vn), .sd_i(line));

  srp_port dut (.mclk_i(mclk), .nrst_i(nrst),
    .register_serial_clock_i(sclk), .register_serial_data_i(line),
    .register_serial_data_o(sd_o), .register_serial_data_oe_o(sd_oe),
    .serial_command_valid_n_i(vn), .serial_data_direction_o(dir),
    .buffered_serial_clock_o(bclk), .gated_phy_serial_data_i(gline),
    .gated_phy_serial_data_o(g_o), .gated_phy_serial_data_oe_o(g_oe),
    .chip_identity_strap_i(strap), .phy_access_i(phy_acc),
    .reg_req_o(req), .reg_rdata_i(rdata));

  // ************************************************************
  // Core model and monitors
  // ************************************************************
  function automatic logic [15:0] word(input logic [4:0] a);
    return {a, ~a, 6'h2C};
  endfunction

  task automatic chk(input logic [16:0] g, e);
    checks_done++;
    if (g !== e) begin
      fail_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  always #10 mclk = ~mclk;

  always @(negedge mclk) begin
    rdata <= word(req.addr);
    wr_n <= wr_n + int'(req.wr === 1'h1);
    rd_n <= rd_n + int'(req.rd === 1'h1);
  end

  always @(negedge sclk) begin
    oe_n <= oe_n + int'(sd_oe === 1'h1);
    // Time-zero edge is only the clock leaving its unknown start
    if ($time > 0) begin
      chk(dir, sd_oe);
      chk(sd_oe & m_oe, 17'h0);
      chk(g_oe & ~phy_acc, 17'h0);
      if (g_oe === 1'h1 && m_oe === 1'h1) chk(g_o, line);
    end
  end

  always @(sclk) #1 chk(bclk, sclk);

  // ************************************************************
  // Scenarios
  // ************************************************************
  task automatic do_reset();
    nrst = 1'h0;
    #1 chk({dir, sd_oe, req.wr, req.rd}, 17'h0);
    repeat (3) m.bit1(1'h0, 1'h1, s);
    @(negedge mclk) nrst = 1'h1;
    repeat (20) @(negedge mclk);
    repeat (2) m.bit1(1'h0, 1'h1, s);
  endtask

  task automatic t_write(input logic [4:0] ra, input logic [15:0] wd);
    int w;
    w = wr_n;
    m.frame(1'h0, ID, ra, wd, q);
    repeat (10) @(negedge mclk);
    chk(17'(wr_n - w), 17'h1);
    chk(req.addr, ra);
    chk(req.wdata, wd);
  endtask

  task automatic t_read(input logic [4:0] ra, id);
    int r;
    r = rd_n;
    m.frame(1'h1, id, ra, 16'h0, q);
    chk(q, {1'h0, word(ra)});
    chk(17'(rd_n - r), 17'h1);
  endtask

  task automatic t_foreign();
    int w;
    int o;
    w = wr_n;
    o = oe_n;
    m.frame(1'h0, ALT, 5'h02, 16'h1234, q);
    m.frame(1'h1, ALT, 5'h02, 16'h0, q);
    chk(q, 17'h1FFFF);
    repeat (10) @(negedge mclk);
    chk(17'(wr_n - w), 17'h0);
    chk(17'(oe_n - o), 17'h0);
  endtask

  task automatic t_abort();
    logic [23:0] v;
    v = {2'h1, 2'h1, ID, 5'h05, 10'h2AA};
    repeat (32) m.bit1(1'h1, 1'h1, s);
    for (int i = 23; i >= 0; i--) m.bit1(1'h1, v[i], s);
    m.hold_invalid(2);
    t_write(5'h06, 16'h5A5A);
  endtask

  task automatic t_pass();
    @(negedge mclk) phy_acc = 1'h1;
    m.frame(1'h1, ALT, 5'h03, 16'h0, q);
    chk(q, 17'h0);
  endtask

  task automatic t_midreset();
    fork
      m.frame(1'h1, ID, 5'h04, 16'h0, q);
    join_none
    #(400 * 52) chk(sd_oe, 17'h1);
    nrst = 1'h0;
    #1 chk({dir, sd_oe, req.wr, req.rd}, 17'h0);
    wait fork;
    @(negedge mclk) nrst = 1'h1;
    repeat (20) @(negedge mclk);
    repeat (2) m.bit1(1'h0, 1'h1, s);
    t_read(5'h04, ALT);
  endtask

  task automatic test_done();
    if (fail_count == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  initial begin
    mclk = 1'h0;
    nrst = 1'h0;
    strap = ID;
    phy_acc = 1'h0;
    phy_val = 1'h0;
    rdata = 16'h0;
    do_reset();
    strap = ALT;
    t_write(5'h00, 16'hFFFF);
    t_write(5'h1F, 16'h8001);
    t_read(5'h1F, ID);
    t_read(5'h00, ID);
    t_foreign();
    t_abort();
    t_pass();
    t_midreset();
    test_done();
  end

  // Whole run is about 285 us of serial traffic
  initial begin
    #1_000_000;
    fail_count++;
    test_done();
  end
endmodule // serial_register_port_tb
